// ===== hw/gpz_map.svh
`ifndef GPZ_MAP_SVH
`define GPZ_MAP_SVH

// ----------------------------------------------------------------------------
// Register indices; the byte address is four times the index.
// ----------------------------------------------------------------------------
`define GPZ_OFS_DATA 4'h0
`define GPZ_OFS_DIR 4'h1
`define GPZ_OFS_PULL 4'h2
`define GPZ_OFS_AIDR 4'h3
`define GPZ_OFS_CTRL 4'h4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define GPZ_RST_DATA 8'h00
`define GPZ_RST_DIR 8'h00
`define GPZ_RST_PULL 8'h00
`define GPZ_RST_AIDR 8'h00
`define GPZ_RST_CTRL 8'h00

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define GPZ_CTRL_PIN_STATE 0
`define GPZ_CTRL_AIN_OFF0 1
`define GPZ_CTRL_NEG_SEL0 2
`define GPZ_CTRL_AIN_OFF1 3
`define GPZ_CTRL_NEG_SEL1 4
`define GPZ_CTRL_MASK 8'h1f

// ----------------------------------------------------------------------------
// Pin positions of shared functions
// ----------------------------------------------------------------------------
`define GPZ_PIN_CMP0_POS 0
`define GPZ_PIN_CMP0_NEG 1
`define GPZ_PIN_CMP0_OUT 2
`define GPZ_PIN_CMP1_POS 3
`define GPZ_PIN_CMP1_NEG 4
`define GPZ_PIN_CMP1_OUT 5

`endif

// ===== hw/gpz_pkg.sv
package gpz_pkg;

	// Eight-bit port word, one bit per pin.
	typedef logic [7:0] gpz_byte_t;

	// AXI response codes.
	typedef enum logic [1:0] {
		GPZ_RESP_OKAY = 2'b00,
		GPZ_RESP_SLVERR = 2'b10
	} gpz_resp_t;

endpackage

// ===== hw/gpz_port.sv
`timescale 1ns/100ps
`include "gpz_map.svh"

// Operation
// - Direction bit 1 makes the pin an output driving the latch.
// - Data writes store into the latch; output pins show it one clock later.
// - Ordinary read of an output pin returns the latch bit.
// - Direction bit 0 makes the pin an input with driver released.
// - Data writes to input pins update the latch without driving.
// - Input pin read gives pin level; read-modify-write read gives latch.
// - Peripheral output drives the pin; reads follow the same split.
// - Ordinary read returns pin level even when a peripheral uses it.
// - Analog disable bit 0 enables analog and blocks digital input.
// - Reset clears direction and analog disable bits.
// - Standby with pin-state bit set floats pins, forces inputs low.
// - In that state, pins with interrupt enabled keep input live.
// - Standby with pin-state bit clear leaves pins unchanged.
// - Pull-up follows its bit but drops while the pin drives low.
// - Each pin level feeds its external interrupt circuit, except in standby float without interrupt enable.
// - Positive comparator input enabled when the analog-off control bit is 0.
// - Negative comparator input needs analog enable and source select 0.
// - Bit n of each port register belongs to pin n.
module gpz_port (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output gpz_pkg::gpz_resp_t s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output gpz_pkg::gpz_resp_t s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic i_rmw_read,
	input wire logic i_standby,
	input wire gpz_pkg::gpz_byte_t i_ext_irq_en,
	input wire logic i_cmp_out_en_ch0,
	input wire logic i_comparator_out_ch0,
	input wire logic i_cmp_out_en_ch1,
	input wire logic i_comparator_out_ch1,
	input wire gpz_pkg::gpz_byte_t i_pin,
	output gpz_pkg::gpz_byte_t o_pin,
	output gpz_pkg::gpz_byte_t o_pin_oe,
	output gpz_pkg::gpz_byte_t o_pullup_en,
	output gpz_pkg::gpz_byte_t o_analog_en,
	output gpz_pkg::gpz_byte_t o_ext_irq_in,
	output logic [1:0] o_cmp_pos_en,
	output logic [1:0] o_cmp_neg_en
);
	import gpz_pkg::*;

	// ------------------------------------------------------------------------
	// Registers and state
	// ------------------------------------------------------------------------
	gpz_byte_t port_data_latch_reg;
	gpz_byte_t port_direction_reg;
	gpz_byte_t port_pullup_enable_reg;
	gpz_byte_t analog_input_disable_low_reg;
	logic [7:0] standby_control_reg;
	gpz_byte_t sync1_reg, sync2_reg, sync3_reg, level_reg;
	logic aw_held_reg, w_held_reg;
	logic [3:0] aw_idx_reg;
	logic [7:0] wdata_reg;
	logic wstrb0_reg;
	logic bvalid_reg, rvalid_reg;
	gpz_resp_t bresp_reg, rresp_reg;
	logic [7:0] rdata_reg;
	gpz_byte_t pin_reg, pin_oe_reg;

	// ------------------------------------------------------------------------
	// Pin input synchroniser and filter
	// ------------------------------------------------------------------------
	// Three stages; the settled level moves only when stages two and three agree.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sync1_reg <= 8'h00;
			sync2_reg <= 8'h00;
			sync3_reg <= 8'h00;
			level_reg <= 8'h00;
		end else begin
			sync1_reg <= i_pin;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			level_reg <= (sync2_reg & sync3_reg) | (level_reg & (sync2_reg ^ sync3_reg));
		end
	end

	// ------------------------------------------------------------------------
	// Pin function selection
	// ------------------------------------------------------------------------
	// Standby float applies only with the pin-state bit set.
	wire standby_pin_state_bit = standby_control_reg[`GPZ_CTRL_PIN_STATE];
	wire standby_hiz = i_standby & standby_pin_state_bit;
	wire [7:0] periph_oe;
	wire [7:0] periph_val;
	wire [7:0] drive_oe;
	wire [7:0] drive_val;
	wire [7:0] input_gate;
	wire [7:0] digital_in;

	// Comparator outputs share pins 2 and 5 and override the port driver.
	assign periph_oe = 8'h00 | ({7'h00, i_cmp_out_en_ch0} << `GPZ_PIN_CMP0_OUT)
		| ({7'h00, i_cmp_out_en_ch1} << `GPZ_PIN_CMP1_OUT);
	assign periph_val = 8'h00 | ({7'h00, i_comparator_out_ch0} << `GPZ_PIN_CMP0_OUT)
		| ({7'h00, i_comparator_out_ch1} << `GPZ_PIN_CMP1_OUT);
	assign drive_oe = (port_direction_reg | periph_oe) & {8{~standby_hiz}};
	assign drive_val = (periph_oe & periph_val) | (~periph_oe & port_data_latch_reg);

	// Digital input needs the analog disable bit at 1 and no standby block.
	assign input_gate = analog_input_disable_low_reg & ~({8{standby_hiz}} & ~i_ext_irq_en);
	assign digital_in = level_reg & input_gate;

	// Pin outputs registered for clean drive.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pin_reg <= 8'h00;
			pin_oe_reg <= 8'h00;
		end else begin
			pin_reg <= drive_val;
			pin_oe_reg <= drive_oe;
		end
	end

	assign o_pin = pin_reg;
	assign o_pin_oe = pin_oe_reg;
	// Pull-up drops while the pin is driven low.
	assign o_pullup_en = port_pullup_enable_reg & ~(pin_oe_reg & ~pin_reg);
	assign o_analog_en = ~analog_input_disable_low_reg;
	// Interrupt circuit sees the pin level, held low only by the standby block.
	assign o_ext_irq_in = level_reg & ~({8{standby_hiz}} & ~i_ext_irq_en);
	// Comparator input enables follow the control bits only.
	assign o_cmp_pos_en[0] = ~standby_control_reg[`GPZ_CTRL_AIN_OFF0];
	assign o_cmp_pos_en[1] = ~standby_control_reg[`GPZ_CTRL_AIN_OFF1];
	assign o_cmp_neg_en[0] = ~(standby_control_reg[`GPZ_CTRL_AIN_OFF0] | standby_control_reg[`GPZ_CTRL_NEG_SEL0]);
	assign o_cmp_neg_en[1] = ~(standby_control_reg[`GPZ_CTRL_AIN_OFF1] | standby_control_reg[`GPZ_CTRL_NEG_SEL1]);

	// ------------------------------------------------------------------------
	// Bus write channel
	// ------------------------------------------------------------------------
	// A word lands once address and data are both held and no response waits.
	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take = s_axi_wvalid & s_axi_wready;
	wire do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
	wire wr_hit = (aw_idx_reg <= `GPZ_OFS_CTRL);
	wire wr_en = do_write & wr_hit & wstrb0_reg;

	assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
	assign s_axi_wready = ~w_held_reg & ~bvalid_reg;

	// Address and data are held until both are present.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			aw_idx_reg <= 4'h0;
			wdata_reg <= 8'h00;
			wstrb0_reg <= 1'b0;
		end else begin
			if (aw_take) begin
				aw_held_reg <= 1'b1;
				aw_idx_reg <= (s_axi_awaddr[31:6] == 26'h0) ? s_axi_awaddr[5:2] : 4'hf;
			end else if (do_write) begin
				aw_held_reg <= 1'b0;
			end
			if (w_take) begin
				w_held_reg <= 1'b1;
				wdata_reg <= s_axi_wdata[7:0];
				wstrb0_reg <= s_axi_wstrb[0];
			end else if (do_write) begin
				w_held_reg <= 1'b0;
			end
		end
	end

	// Write response; unmapped addresses answer with a slave error.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= GPZ_RESP_OKAY;
		end else if (do_write) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= wr_hit ? GPZ_RESP_OKAY : GPZ_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;

	// ------------------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------------------
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			port_data_latch_reg <= `GPZ_RST_DATA;
			port_direction_reg <= `GPZ_RST_DIR;
			port_pullup_enable_reg <= `GPZ_RST_PULL;
			analog_input_disable_low_reg <= `GPZ_RST_AIDR;
			standby_control_reg <= `GPZ_RST_CTRL;
		end else if (wr_en) begin
			case (aw_idx_reg)
				`GPZ_OFS_DATA: port_data_latch_reg <= wdata_reg;
				`GPZ_OFS_DIR: port_direction_reg <= wdata_reg;
				`GPZ_OFS_PULL: port_pullup_enable_reg <= wdata_reg;
				`GPZ_OFS_AIDR: analog_input_disable_low_reg <= wdata_reg;
				`GPZ_OFS_CTRL: standby_control_reg <= wdata_reg & `GPZ_CTRL_MASK;
				default: port_data_latch_reg <= port_data_latch_reg;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Bus read channel
	// ------------------------------------------------------------------------
	// Output-port bits read the latch, the rest read the pin; RMW reads the latch.
	wire [7:0] port_read = (port_direction_reg & ~periph_oe & port_data_latch_reg)
		| (~(port_direction_reg & ~periph_oe) & digital_in);
	wire [7:0] data_read = i_rmw_read ? port_data_latch_reg : port_read;
	wire ar_take = s_axi_arvalid & s_axi_arready;
	wire ar_top_ok = (s_axi_araddr[31:6] == 26'h0);
	wire [3:0] ar_idx = s_axi_araddr[5:2];
	wire rd_hit = ar_top_ok & (ar_idx <= `GPZ_OFS_CTRL);
	// Register select; unmapped indices read back zero.
	wire [7:0] rd_mux = (ar_idx == `GPZ_OFS_DATA) ? data_read :
		(ar_idx == `GPZ_OFS_DIR) ? port_direction_reg :
		(ar_idx == `GPZ_OFS_PULL) ? port_pullup_enable_reg :
		(ar_idx == `GPZ_OFS_AIDR) ? analog_input_disable_low_reg : standby_control_reg;

	assign s_axi_arready = ~rvalid_reg;

	// Read data is captured at the address handshake.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 8'h00;
			rresp_reg <= GPZ_RESP_OKAY;
		end else if (ar_take) begin
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_hit ? rd_mux : 8'h00;
			rresp_reg <= rd_hit ? GPZ_RESP_OKAY : GPZ_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = {24'h000000, rdata_reg};
	assign s_axi_rresp = rresp_reg;

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	// Pin drive, latch and standby float.
	out_drive_a: assert property ((port_direction_reg[0] & ~standby_hiz) |=> o_pin_oe[0])
		else $error("output pin 0 not driven");
	latch_shown_a: assert property (wr_en && aw_idx_reg == `GPZ_OFS_DATA && !standby_hiz
		##1 !standby_hiz |=> o_pin == $past(wdata_reg, 2) || periph_oe != 8'h00)
		else $error("written latch not on pins");
	latch_store_a: assert property (wr_en && aw_idx_reg == `GPZ_OFS_DATA
		|=> port_data_latch_reg == $past(wdata_reg))
		else $error("data write not stored in latch");
	in_release_a: assert property (!port_direction_reg[6] |=> !o_pin_oe[6])
		else $error("input pin 6 driven");
	cmp0_drive_a: assert property (i_cmp_out_en_ch0 |=> o_pin_oe[`GPZ_PIN_CMP0_OUT] == !$past(standby_hiz)
		&& o_pin[`GPZ_PIN_CMP0_OUT] == $past(i_comparator_out_ch0))
		else $error("comparator 0 output not on its pin");
	cmp1_drive_a: assert property (i_cmp_out_en_ch1 |=> o_pin_oe[`GPZ_PIN_CMP1_OUT] == !$past(standby_hiz)
		&& o_pin[`GPZ_PIN_CMP1_OUT] == $past(i_comparator_out_ch1))
		else $error("comparator 1 output not on its pin");
	hold_drive_a: assert property (i_standby && !standby_hiz && port_direction_reg[0] |=> o_pin_oe[0])
		else $error("output dropped in plain standby");
	standby_hiz_a: assert property (standby_hiz |=> o_pin_oe == 8'h00)
		else $error("pins driven in standby float");

	// Register reads and the read-modify-write split.
	out_read_a: assert property (ar_take && rd_hit && ar_idx == `GPZ_OFS_DATA && port_direction_reg[1]
		&& !periph_oe[1] |=> s_axi_rdata[1] == $past(port_data_latch_reg[1]))
		else $error("output read not from latch");
	rmw_read_a: assert property (ar_take && ar_idx == `GPZ_OFS_DATA && ar_top_ok && i_rmw_read
		|=> s_axi_rdata[7:0] == $past(port_data_latch_reg))
		else $error("rmw read not from latch");
	in_read_a: assert property (ar_take && ar_idx == `GPZ_OFS_DATA && ar_top_ok && !i_rmw_read
		&& !port_direction_reg[6] |=> s_axi_rdata[6] == $past(digital_in[6]))
		else $error("input read not from pin");
	periph_read_a: assert property (ar_take && ar_idx == `GPZ_OFS_DATA && ar_top_ok && !i_rmw_read
		&& periph_oe[2] |=> s_axi_rdata[2] == $past(digital_in[2]))
		else $error("peripheral pin read not from pin");
	read_ok_a: assert property (ar_take && rd_hit |=> s_axi_rvalid && s_axi_rresp == GPZ_RESP_OKAY)
		else $error("mapped read refused");

	// Input gating, interrupt feed, pull-ups and comparator enables.
	analog_block_a: assert property (!analog_input_disable_low_reg[3] |-> !digital_in[3] && o_analog_en[3])
		else $error("digital input not blocked");
	digital_open_a: assert property (analog_input_disable_low_reg[3] && !standby_hiz
		|-> digital_in[3] == level_reg[3])
		else $error("digital input not open");
	irq_live_a: assert property (standby_hiz && i_ext_irq_en[4] |-> o_ext_irq_in[4] == level_reg[4])
		else $error("interrupt input blocked");
	irq_low_a: assert property (standby_hiz && !i_ext_irq_en[4] |-> !o_ext_irq_in[4])
		else $error("interrupt input not forced low");
	irq_feed_a: assert property (!standby_hiz |-> o_ext_irq_in == level_reg)
		else $error("interrupt input not fed from pin");
	pull_low_a: assert property (o_pin_oe[2] && !o_pin[2] |-> !o_pullup_en[2])
		else $error("pull-up on low output");
	pull_follow_a: assert property (!(o_pin_oe[5] && !o_pin[5])
		|-> o_pullup_en[5] == port_pullup_enable_reg[5])
		else $error("pull-up not following its bit");
	cmp_neg_a: assert property (o_cmp_neg_en[0] |-> o_cmp_pos_en[0])
		else $error("negative enable without analog enable");
	cmp_neg1_a: assert property (o_cmp_neg_en[1] |-> o_cmp_pos_en[1])
		else $error("negative enable without analog enable");

	// Bus handshakes.
	resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	unmapped_resp_a: assert property (do_write && !wr_hit |=> s_axi_bresp == GPZ_RESP_SLVERR)
		else $error("unmapped write not refused");
	read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("address taken while read pending");

	// Main scenarios.
	cov_write_c: cover property (wr_en && aw_idx_reg == `GPZ_OFS_DATA);
	cov_rmw_c: cover property (ar_take && i_rmw_read);
	cov_standby_c: cover property (standby_hiz ##1 !standby_hiz);
	cov_cmp_c: cover property (i_cmp_out_en_ch0 && o_pin_oe[`GPZ_PIN_CMP0_OUT]);
	cov_float_irq_c: cover property (standby_hiz && i_ext_irq_en != 8'h00);

endmodule // gpz_port

// ===== tb/gpz_pad_model.sv
`timescale 1ns/100ps

// ----------------------------------------------------------------------------
// Pad model
// ----------------------------------------------------------------------------
module gpz_pad_model (
	input wire logic i_clk,
	input wire gpz_pkg::gpz_byte_t i_drv,
	input wire gpz_pkg::gpz_byte_t i_drv_oe,
	input wire gpz_pkg::gpz_byte_t i_pull,
	input wire gpz_pkg::gpz_byte_t i_ext,
	input wire gpz_pkg::gpz_byte_t i_ext_en,
	output gpz_pkg::gpz_byte_t o_pad
);
	import gpz_pkg::*;
	gpz_byte_t float_reg = 8'h55;

	// An open pin with no pull-up wanders, so it must never look like a held level.
	always @(posedge i_clk) begin
		float_reg <= ~float_reg;
	end

	// The chip driver wins, then the outside driver, then the pull-up.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (i_drv_oe[i])
				o_pad[i] = i_drv[i];
			else if (i_ext_en[i])
				o_pad[i] = i_ext[i];
			else if (i_pull[i])
				o_pad[i] = 1'b1;
			else
				o_pad[i] = float_reg[i];
		end
	end
endmodule // gpz_pad_model

// ===== tb/gpz_port_tb.sv
`timescale 1ns/100ps
`include "gpz_map.svh"

// ----------------------------------------------------------------------------
// Testbench of the port
// ----------------------------------------------------------------------------
module gpz_port_tb;
	import gpz_pkg::*;
	logic i_clk = 1'b0, i_rst = 1'b1;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rd_d;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, rmw = 1'b0, standby = 1'b0;
	logic cen0 = 1'b0, cval0 = 1'b0, cen1 = 1'b0, cval1 = 1'b0;
	logic [1:0] pos_en, neg_en;
	logic [31:0] rdata;
	gpz_resp_t bresp, rresp, rd_r, wr_r;
	gpz_byte_t irq_en = 8'h00, ext = 8'h00, ext_en = 8'h00, pad, drv, drv_oe, pull, ana, irq_in;
	int bad_count = 0, n_tests = 0;

	always #4 i_clk = ~i_clk;

	gpz_port i_dut (.i_clk(i_clk), .i_rst(i_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .i_rmw_read(rmw),
		.i_standby(standby), .i_ext_irq_en(irq_en), .i_cmp_out_en_ch0(cen0), .i_comparator_out_ch0(cval0),
		.i_cmp_out_en_ch1(cen1), .i_comparator_out_ch1(cval1), .i_pin(pad), .o_pin(drv),
		.o_pin_oe(drv_oe), .o_pullup_en(pull), .o_analog_en(ana), .o_ext_irq_in(irq_in),
		.o_cmp_pos_en(pos_en), .o_cmp_neg_en(neg_en));

	gpz_pad_model i_pads (.i_clk(i_clk), .i_drv(drv), .i_drv_oe(drv_oe), .i_pull(pull), .i_ext(ext),
		.i_ext_en(ext_en), .o_pad(pad));

	// ------------------------------------------------------------------------
	// Bus tasks and comparison
	// ------------------------------------------------------------------------
	// Byte address of a register index.
	function automatic logic [31:0] ra(input logic [3:0] idx);
		return {26'h0, idx, 2'b00};
	endfunction

	// Write one word; readies are sampled mid-cycle and acted on at the next edge.
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic ah, wh, ad, wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge i_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge i_clk);
			ah = awready & ~ad;
			wh = wready & ~wd;
			@(posedge i_clk);
			if (ah) awvalid <= 1'b0;
			if (wh) wvalid <= 1'b0;
			ad = ad | ah;
			wd = wd | wh;
		end while (!(ad && wd));
		do begin
			@(negedge i_clk);
			ah = bvalid;
			wr_r = bresp;
			@(posedge i_clk);
		end while (!ah);
		bready <= 1'b0;
	endtask

	// Read one word, optionally marked as read-modify-write.
	task automatic rd(input logic [31:0] a, input logic m);
		logic h;
		@(posedge i_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rmw <= m;
		rready <= 1'b1;
		do begin
			@(negedge i_clk);
			h = arready;
			@(posedge i_clk);
		end while (!h);
		arvalid <= 1'b0;
		rmw <= 1'b0;
		do begin
			@(negedge i_clk);
			h = rvalid;
			rd_d = rdata;
			rd_r = rresp;
			@(posedge i_clk);
		end while (!h);
		rready <= 1'b0;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic settle();
		repeat (6) @(posedge i_clk);
	endtask

	task automatic end_sim();
		if (bad_count == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ------------------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------------------
	// Software clears unused shared outputs and interrupts before each use.
	initial begin
		repeat (6) @(posedge i_clk);
		i_rst <= 1'b0;
		rd(ra(`GPZ_OFS_DIR), 1'b0); chk("dir reset", rd_d, 32'h0);
		rd(ra(`GPZ_OFS_AIDR), 1'b0); chk("aidr reset", rd_d, 32'h0);
		chk("oe reset", drv_oe, 32'h0);
		chk("analog reset", ana, 32'hff);
		rd(32'h40, 1'b0); chk("unmapped resp", rd_r, GPZ_RESP_SLVERR);
		wr(32'h40, 32'hff); chk("unmapped wresp", wr_r, GPZ_RESP_SLVERR);
		ext <= 8'h3c;
		ext_en <= 8'hff;
		wr(ra(`GPZ_OFS_AIDR), 32'hff); wr(ra(`GPZ_OFS_DIR), 32'h0f); wr(ra(`GPZ_OFS_DATA), 32'ha5);
		chk("wresp", wr_r, GPZ_RESP_OKAY);
		settle();
		chk("oe", drv_oe, 32'h0f);
		chk("drive", drv & 8'h0f, 32'h05);
		rd(ra(`GPZ_OFS_DATA), 1'b0); chk("read", rd_d, 32'h35);
		rd(ra(`GPZ_OFS_DATA), 1'b1); chk("rmw read", rd_d, 32'ha5);
		chk("irq level", irq_in, 32'h35);
		wr(ra(`GPZ_OFS_DATA), 32'h5a);
		settle();
		chk("oe input", drv_oe, 32'h0f);
		rd(ra(`GPZ_OFS_DATA), 1'b1); chk("latch", rd_d, 32'h5a);
		wr(ra(`GPZ_OFS_AIDR), 32'h0f);
		settle();
		rd(ra(`GPZ_OFS_DATA), 1'b0); chk("blocked", rd_d, 32'h0a);
		chk("analog en", ana, 32'hf0);
		wr(ra(`GPZ_OFS_PULL), 32'hff);
		chk("pullup", pull, 32'hfa);
		cen0 <= 1'b1;
		cval0 <= 1'b1;
		cen1 <= 1'b1;
		settle();
		chk("periph out", {drv_oe[2], drv[2]}, 32'h3);
		chk("periph out 1", {drv_oe[5], drv[5]}, 32'h2);
		rd(ra(`GPZ_OFS_DATA), 1'b0); chk("periph read", rd_d, 32'h0e);
		rd(ra(`GPZ_OFS_DATA), 1'b1); chk("periph rmw", rd_d, 32'h5a);
		cen0 <= 1'b0;
		cen1 <= 1'b0;
		wr(ra(`GPZ_OFS_AIDR), 32'hff);
		wr(ra(`GPZ_OFS_CTRL), 32'h01);
		irq_en <= 8'h10;
		standby <= 1'b1;
		settle();
		chk("float oe", drv_oe, 32'h0);
		chk("float irq", irq_in, 32'h10);
		rd(ra(`GPZ_OFS_DATA), 1'b0); chk("float read", rd_d, 32'h1a);
		standby <= 1'b0;
		wr(ra(`GPZ_OFS_CTRL), 32'h00);
		standby <= 1'b1;
		settle();
		chk("hold oe", drv_oe, 32'h0f);
		chk("hold irq", irq_in, 32'h3a);
		standby <= 1'b0;
		for (int c = 0; c < 32; c++) begin
			wr(ra(`GPZ_OFS_CTRL), c);
			chk("cmp en", {pos_en, neg_en}, {~c[3], ~c[1], ~c[3] & ~c[4], ~c[1] & ~c[2]});
		end
		end_sim();
	end

	// Watchdog for a hung handshake.
	initial begin
		repeat (20000) @(posedge i_clk);
		bad_count++;
		end_sim();
	end
endmodule // gpz_port_tb
